// *** rtl/irq_enable_pkg.sv ***
// Package for the sensor interrupt enable and masking block: register offsets,
// enable field positions, event carriers and the CRC constants.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package irq_enable_pkg;

	// Register offsets on the plain register port.
	localparam logic [3:0] ADDR_CTRL   = 4'h0; // Master, CRC and group enables.
	localparam logic [3:0] ADDR_EVT_EN = 4'h1; // Threshold, FIFO and conversion enables.
	localparam logic [3:0] ADDR_CHK_EN = 4'h2; // Per-channel underflow and overflow checks.
	localparam logic [3:0] ADDR_LEVEL  = 4'h3; // FIFO level count.
	localparam logic [3:0] ADDR_STATUS = 4'h4; // Live masked event view, read only.
	localparam logic [3:0] ADDR_CRC    = 4'h5; // Running memory CRC, read only.

	// Field positions in the control register.
	localparam int CTRL_MASTER  = 0;
	localparam int CTRL_CRC_COM = 1;
	localparam int CTRL_CRC_REG = 2;
	localparam int CTRL_ADC_GRP = 3;
	localparam int CTRL_CALC_GRP = 4;
	localparam int CTRL_SNS_GRP = 5;
	localparam int CTRL_CRC_USR = 6;
	localparam int CTRL_W       = 7;

	// Field positions in the event enable register.
	localparam int EVT_PHIGH = 0;
	localparam int EVT_PLOW  = 1;
	localparam int EVT_THIGH = 2;
	localparam int EVT_TLOW  = 3;
	localparam int EVT_FULL  = 4;
	localparam int EVT_EMPTY = 5;
	localparam int EVT_LEVEL = 6;
	localparam int EVT_DONE  = 7;
	localparam int EVT_W     = 8;

	// Field positions in the check enable register.
	localparam int CHK_CONV_UNDER_T1 = 0;
	localparam int CHK_CONV_UNDER_P  = 1;
	localparam int CHK_CONV_OVER_T1  = 2;
	localparam int CHK_CONV_OVER_P   = 3;
	localparam int CHK_MATH_UNDER_T1 = 4;
	localparam int CHK_MATH_UNDER_P  = 5;
	localparam int CHK_MATH_OVER_T1  = 6;
	localparam int CHK_MATH_OVER_P   = 7;
	localparam int CHK_W             = 8;

	// Status register layout: events, then ADC, math, sensor, CRC errors.
	localparam int STAT_ADC  = 8;
	localparam int STAT_MATH = 9;
	localparam int STAT_SNS  = 10;
	localparam int STAT_COM  = 11;
	localparam int STAT_MEM  = 12;
	localparam int STAT_USR  = 13;

	// FIFO figures.
	localparam int FIFO_FULL_COUNT = 32;
	localparam int FIFO_CNT_W      = 6;

	// Reset values; every enable is cleared.
	localparam logic [CTRL_W-1:0]     CTRL_RST  = 7'h00;
	localparam logic [EVT_W-1:0]      EVT_RST   = 8'h00;
	localparam logic [CHK_W-1:0]      CHK_RST   = 8'h00;
	localparam logic [FIFO_CNT_W-1:0] LEVEL_RST = 6'h00;

	// CRC-8 over memory bytes, polynomial x^8+x^2+x+1.
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CRC_INIT = 8'hFF;

	// Measurement and threshold set from the sensing path.
	typedef struct packed {
		logic [23:0] press;
		logic [23:0] temp;
		logic [23:0] p_high;
		logic [23:0] p_low;
		logic [23:0] t_high;
		logic [23:0] t_low;
	} meas_type;

	// Raw per-channel range flags from converter and compensation math.
	// The first member is bit 7, so bit i lines up with check enable bit i.
	typedef struct packed {
		logic math_over_press;
		logic math_over_temp1;
		logic math_under_press;
		logic math_under_temp1;
		logic conv_over_press;
		logic conv_over_temp1;
		logic conv_under_press;
		logic conv_under_temp1;
	} range_type;

endpackage : irq_enable_pkg

// *** rtl/sensor_irq_enable.sv ***
// Interrupt enable and masking logic of the pressure and temperature sensor.
// Assumes measurement, FIFO, range and bus CRC inputs are synchronous to
// REF_CLK_IN, and that software writes the enables over the plain register port.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/10ps

// Operation
// - Master enable low masks every interrupt source regardless of other enables.
// - Communication CRC enable makes a bus CRC mismatch a reportable event.
// - Memory CRC enable checks internal register memory contents by CRC.
// - ADC group enable gates all ADC error conditions.
// - Calculation group enable gates all calculation error conditions.
// - Sensor group enable gates all sensor error conditions.
// - Detect pressure above the upper pressure threshold when enabled.
// - Detect pressure below the lower pressure threshold when enabled.
// - Detect temperature above the upper temperature threshold when enabled.
// - Detect temperature below the lower temperature threshold when enabled.
// - Signal FIFO full once 32 unread values are held, when enabled.
// - Signal FIFO empty once every stored value is read, when enabled.
// - Signal FIFO level once unread count reaches programmed count, when enabled.
// - Signal an event each time a conversion completes, when enabled.
// - Separate ADC underflow check enables for temperature 1 and pressure.
// - Separate ADC overflow check enables for temperature 1 and pressure.
// - Separate calculation underflow check enables for temperature 1 and pressure.
// - Separate calculation overflow check enables for temperature 1 and pressure.
// - User memory CRC protection applies when its enable is set.
module sensor_irq_enable
	import irq_enable_pkg::*;
(
	// Clock and reset.
	input  wire logic                  REF_CLK_IN,
	input  wire logic                  RST_B_IN,
	// Register port.
	input  wire logic [3:0]            REG_ADDR_IN,
	input  wire logic [31:0]           REG_WDATA_IN,
	input  wire logic                  REG_WR_IN,
	input  wire logic                  REG_RD_IN,
	output logic      [31:0]           REG_RDATA_OUT,
	// Measurement path.
	input  wire meas_type              MEAS_IN,
	input  wire logic                  CONV_DONE_IN,
	input  wire range_type             RANGE_IN,
	input  wire logic                  SENSOR_FAULT_IN,
	// FIFO occupancy.
	input  wire logic [FIFO_CNT_W-1:0] FIFO_COUNT_IN,
	// Bus CRC compare from the serial interface.
	input  wire logic                  BUS_FRAME_END_IN,
	input  wire logic [7:0]            BUS_CRC_CALC_IN,
	input  wire logic [7:0]            BUS_CRC_RECV_IN,
	// Register memory byte stream for CRC, and stored reference.
	input  wire logic                  MEM_BYTE_VALID_IN,
	input  wire logic [7:0]            MEM_BYTE_IN,
	input  wire logic                  MEM_BYTE_USER_IN,
	input  wire logic                  MEM_SCAN_END_IN,
	input  wire logic [7:0]            MEM_CRC_REF_IN,
	input  wire logic [7:0]            USR_CRC_REF_IN,
	// Interrupt indication.
	output logic                       IRQ_OUT
);

	logic [CTRL_W-1:0]     ctrl_q;
	logic [EVT_W-1:0]      evt_en_q;
	logic [CHK_W-1:0]      chk_en_q;
	logic [FIFO_CNT_W-1:0] level_q;
	logic [7:0]            crc_mem_q;
	logic [7:0]            crc_usr_q;
	logic [7:0]            crc_mem_d;
	logic [7:0]            crc_usr_d;
	logic                  com_err_q;
	logic                  mem_err_q;
	logic                  usr_err_q;
	logic [FIFO_CNT_W-1:0] fifo_prev_q;
	logic [EVT_W-1:0]      evt_raw;
	logic [EVT_W-1:0]      evt_masked;
	logic [CHK_W-1:0]      chk_raw;
	logic                  adc_err;
	logic                  math_err;
	logic                  sns_err;
	logic [13:0]           status;

	// One CRC-8 byte step, shared by both memory checks.
	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
		end
		return c;
	endfunction : crc8_step

	// Enable registers written by software, all cleared at reset.
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl_q   <= CTRL_RST;
			evt_en_q <= EVT_RST;
			chk_en_q <= CHK_RST;
			level_q  <= LEVEL_RST;
		end else if (REG_WR_IN) begin
			case (REG_ADDR_IN)
				ADDR_CTRL:   ctrl_q   <= REG_WDATA_IN[CTRL_W-1:0];
				ADDR_EVT_EN: evt_en_q <= REG_WDATA_IN[EVT_W-1:0];
				ADDR_CHK_EN: chk_en_q <= REG_WDATA_IN[CHK_W-1:0];
				ADDR_LEVEL:  level_q  <= REG_WDATA_IN[FIFO_CNT_W-1:0];
				default: ;
			endcase
		end
	end

	// Previous FIFO count, so full, empty and level fire on arrival only.
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			fifo_prev_q <= '0;
		end else begin
			fifo_prev_q <= FIFO_COUNT_IN;
		end
	end

	// Raw events from thresholds, FIFO and conversion.
	always_comb begin
		evt_raw            = '0;
		evt_raw[EVT_PHIGH] = CONV_DONE_IN && (MEAS_IN.press > MEAS_IN.p_high);
		evt_raw[EVT_PLOW]  = CONV_DONE_IN && (MEAS_IN.press < MEAS_IN.p_low);
		evt_raw[EVT_THIGH] = CONV_DONE_IN && (MEAS_IN.temp > MEAS_IN.t_high);
		evt_raw[EVT_TLOW]  = CONV_DONE_IN && (MEAS_IN.temp < MEAS_IN.t_low);
		evt_raw[EVT_FULL]  = (FIFO_COUNT_IN == FIFO_CNT_W'(FIFO_FULL_COUNT))
			&& (fifo_prev_q != FIFO_CNT_W'(FIFO_FULL_COUNT));
		evt_raw[EVT_EMPTY] = (FIFO_COUNT_IN == '0) && (fifo_prev_q != '0);
		evt_raw[EVT_LEVEL] = (FIFO_COUNT_IN == level_q) && (fifo_prev_q != level_q);
		evt_raw[EVT_DONE]  = CONV_DONE_IN;
	end

	// Each event only through its own enable.
	assign evt_masked = evt_raw & evt_en_q;

	// Per-channel range checks, each with its own enable.
	assign chk_raw = RANGE_IN & chk_en_q;

	// Group gating of the error classes.
	assign adc_err  = ctrl_q[CTRL_ADC_GRP] && (|chk_raw[CHK_CONV_OVER_P:CHK_CONV_UNDER_T1]);
	assign math_err = ctrl_q[CTRL_CALC_GRP] && (|chk_raw[CHK_MATH_OVER_P:CHK_MATH_UNDER_T1]);
	assign sns_err  = ctrl_q[CTRL_SNS_GRP] && SENSOR_FAULT_IN;

	// Bus CRC mismatch flag, held for one cycle after a frame end.
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			com_err_q <= 1'b0;
		end else begin
			com_err_q <= ctrl_q[CTRL_CRC_COM] && BUS_FRAME_END_IN
				&& (BUS_CRC_CALC_IN != BUS_CRC_RECV_IN);
		end
	end

	// Next values of the running memory CRCs.
	always_comb begin
		crc_mem_d = crc_mem_q;
		crc_usr_d = crc_usr_q;
		if (MEM_BYTE_VALID_IN) begin
			if (MEM_BYTE_USER_IN) begin
				crc_usr_d = crc8_step(crc_usr_q, MEM_BYTE_IN);
			end else begin
				crc_mem_d = crc8_step(crc_mem_q, MEM_BYTE_IN);
			end
		end
	end

	// Memory scans; a mismatch at scan end is a one-cycle error.
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			crc_mem_q <= CRC_INIT;
			crc_usr_q <= CRC_INIT;
			mem_err_q <= 1'b0;
			usr_err_q <= 1'b0;
		end else if (MEM_SCAN_END_IN) begin
			mem_err_q <= ctrl_q[CTRL_CRC_REG] && (crc_mem_d != MEM_CRC_REF_IN);
			usr_err_q <= ctrl_q[CTRL_CRC_USR] && (crc_usr_d != USR_CRC_REF_IN);
			crc_mem_q <= CRC_INIT;
			crc_usr_q <= CRC_INIT;
		end else begin
			mem_err_q <= 1'b0;
			usr_err_q <= 1'b0;
			crc_mem_q <= crc_mem_d;
			crc_usr_q <= crc_usr_d;
		end
	end

	// Status view of every qualified source.
	assign status = {usr_err_q, mem_err_q, com_err_q, sns_err, math_err, adc_err, evt_masked};

	// Interrupt pulse only when the master enable is also set.
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			IRQ_OUT <= 1'b0;
		end else begin
			IRQ_OUT <= ctrl_q[CTRL_MASTER] && (|status);
		end
	end

	// Read data, one cycle after the strobe; unmapped reads return zero.
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			REG_RDATA_OUT <= '0;
		end else if (REG_RD_IN) begin
			case (REG_ADDR_IN)
				ADDR_CTRL:   REG_RDATA_OUT <= 32'(ctrl_q);
				ADDR_EVT_EN: REG_RDATA_OUT <= 32'(evt_en_q);
				ADDR_CHK_EN: REG_RDATA_OUT <= 32'(chk_en_q);
				ADDR_LEVEL:  REG_RDATA_OUT <= 32'(level_q);
				ADDR_STATUS: REG_RDATA_OUT <= 32'(status);
				ADDR_CRC:    REG_RDATA_OUT <= {16'h0000, crc_usr_q, crc_mem_q};
				default:     REG_RDATA_OUT <= '0;
			endcase
		end else begin
			REG_RDATA_OUT <= '0;
		end
	end

endmodule : sensor_irq_enable

// *** dv/irq_enable_checker_assertions.sv ***
// Checker for the interrupt enable block, watching only its top-level ports.
// Assumes one clock domain; it keeps shadow copies of the control and event enables.
`timescale 1ns/10ps
module irq_enable_checker
	import irq_enable_pkg::*;
(
	// Clock and reset.
	input  wire logic        REF_CLK_IN,
	input  wire logic        RST_B_IN,
	// Register port.
	input  wire logic [3:0]  REG_ADDR_IN,
	input  wire logic [31:0] REG_WDATA_IN,
	input  wire logic        REG_WR_IN,
	input  wire logic        REG_RD_IN,
	input  wire logic [31:0] REG_RDATA_OUT,
	// Event sources and the interrupt.
	input  wire meas_type    MEAS_IN,
	input  wire logic        CONV_DONE_IN,
	input  wire logic        SENSOR_FAULT_IN,
	input  wire logic        IRQ_OUT
);
	logic [CTRL_W-1:0] ctrl_q;
	logic [EVT_W-1:0]  evt_q;
	logic              on;
	default clocking @(posedge REF_CLK_IN); endclocking
	default disable iff (!RST_B_IN);
	// Shadow enables follow every write, so checks see what the block holds.
	always_ff @(posedge REF_CLK_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			ctrl_q <= CTRL_RST;
			evt_q  <= EVT_RST;
		end else if (REG_WR_IN && REG_ADDR_IN == ADDR_CTRL) begin
			ctrl_q <= REG_WDATA_IN[CTRL_W-1:0];
		end else if (REG_WR_IN && REG_ADDR_IN == ADDR_EVT_EN) begin
			evt_q <= REG_WDATA_IN[EVT_W-1:0];
		end
	end
	// The master enable in the shadow copy.
	assign on = ctrl_q[CTRL_MASTER];
	a_master_mask: assert property (!on |=> !IRQ_OUT)
		else $error("interrupt while master enable clear");
	a_quiet_all: assert property ((ctrl_q[6:1] == 6'h00 && evt_q == 8'h00) [*2] |=> !IRQ_OUT)
		else $error("interrupt with every enable clear");
	a_read_idle: assert property (!REG_RD_IN |=> REG_RDATA_OUT == 32'h0)
		else $error("read data outside the read cycle");
	a_read_ctrl: assert property (REG_RD_IN && REG_ADDR_IN == ADDR_CTRL |=> REG_RDATA_OUT == {25'h0, ctrl_q})
		else $error("control read back wrong");
	a_done_irq: assert property (CONV_DONE_IN && on && evt_q[EVT_DONE] |=> IRQ_OUT)
		else $error("conversion done not reported");
	a_press_high: assert property (CONV_DONE_IN && on && evt_q[EVT_PHIGH] && MEAS_IN.press > MEAS_IN.p_high |=> IRQ_OUT)
		else $error("high pressure not reported");
	a_temp_low: assert property (CONV_DONE_IN && on && evt_q[EVT_TLOW] && MEAS_IN.temp < MEAS_IN.t_low |=> IRQ_OUT)
		else $error("low temperature not reported");
	a_sensor_grp: assert property (SENSOR_FAULT_IN && on && ctrl_q[CTRL_SNS_GRP] |=> IRQ_OUT)
		else $error("sensor error not reported");
	c_done: cover property (CONV_DONE_IN && on ##1 IRQ_OUT);
	c_read: cover property (REG_RD_IN && REG_ADDR_IN == ADDR_CTRL);
	c_fault: cover property (SENSOR_FAULT_IN && on ##1 IRQ_OUT);
endmodule : irq_enable_checker

bind sensor_irq_enable irq_enable_checker u_chk (.REF_CLK_IN, .RST_B_IN, .REG_ADDR_IN,
	.REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .MEAS_IN, .CONV_DONE_IN,
	.SENSOR_FAULT_IN, .IRQ_OUT);

// *** dv/bus_host_model.sv ***
// Behavioural bus host: ends frames carrying a matching or a broken CRC byte.
// Assumes the block's clock; between frames the CRC bytes keep changing.
`timescale 1ns/10ps
module bus_host_model (
	// Clock, reset and frame request.
	input  wire logic       clk_in,
	input  wire logic       rst_b_in,
	input  wire logic       send_in,
	input  wire logic       bad_in,
	// Frame end strobe and the two CRC bytes.
	output logic            end_out,
	output logic [7:0]      calc_out,
	output logic [7:0]      recv_out
);
	// A frame ends one cycle after a request; idle bytes never hold still.
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			end_out  <= 1'b0;
			calc_out <= 8'h00;
			recv_out <= 8'hFF;
		end else if (send_in) begin
			end_out  <= 1'b1;
			calc_out <= 8'h5A;
			recv_out <= bad_in ? 8'hA5 : 8'h5A;
		end else begin
			end_out  <= 1'b0;
			calc_out <= calc_out + 8'h13;
			recv_out <= ~recv_out;
		end
	end
endmodule : bus_host_model

// *** dv/sensor_irq_enable_bench.sv ***
// Testbench for the interrupt enable block: register tasks and event checks.
// Assumes the bus host model drives the bus CRC compare inputs.
`timescale 1ns/10ps
module sensor_irq_enable_bench
	import irq_enable_pkg::*;
;
	logic clk, rst_b, wr, rd, done, fault, send, bad, fe, mv, mu, mse, irq;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata;
	logic [7:0]  cc, cr, mb, mref, uref;
	logic [5:0]  fcnt;
	meas_type    meas;
	range_type   rng;
	int          failures, checks;
	sensor_irq_enable u_sensor_irq_enable (.REF_CLK_IN(clk), .RST_B_IN(rst_b),
		.REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr), .REG_RD_IN(rd),
		.REG_RDATA_OUT(rdata), .MEAS_IN(meas), .CONV_DONE_IN(done), .RANGE_IN(rng),
		.SENSOR_FAULT_IN(fault), .FIFO_COUNT_IN(fcnt), .BUS_FRAME_END_IN(fe),
		.BUS_CRC_CALC_IN(cc), .BUS_CRC_RECV_IN(cr), .MEM_BYTE_VALID_IN(mv), .MEM_BYTE_IN(mb),
		.MEM_BYTE_USER_IN(mu), .MEM_SCAN_END_IN(mse), .MEM_CRC_REF_IN(mref),
		.USR_CRC_REF_IN(uref), .IRQ_OUT(irq));
	bus_host_model u_bus_host_model (.clk_in(clk), .rst_b_in(rst_b), .send_in(send),
		.bad_in(bad), .end_out(fe), .calc_out(cc), .recv_out(cr));
	// Free-running 100 MHz clock.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Compares one result and reports a mismatch at once.
	task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : cmp
	task wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data stand only in the cycle after the strobe.
	task rd_chk(input logic [3:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		cmp("REG_RDATA_OUT", e, rdata);
	endtask : rd_chk
	// Ends the pulse sources, then looks at the interrupt lag cycles later.
	task ev(input int lag, input logic e);
		@(posedge clk);
		done <= 1'b0;
		send <= 1'b0;
		mv <= 1'b0;
		mse <= 1'b0;
		repeat (lag - 1) @(posedge clk);
		#1;
		cmp("IRQ_OUT", {31'h0, e}, {31'h0, irq});
	endtask : ev
	// Thresholds 100 and 50; case 0 to 3 crosses one limit, 4 crosses none.
	function automatic meas_type mk(input int i);
		meas_type m;
		m = '{24'h0A0, 24'h0A0, 24'h100, 24'h050, 24'h100, 24'h050};
		if (i == 0) m.press = 24'h200;
		if (i == 1) m.press = 24'h010;
		if (i == 2) m.temp = 24'h200;
		if (i == 3) m.temp = 24'h010;
		return m;
	endfunction : mk
	// Bitwise CRC-8 of one byte from the initial value, most significant bit first.
	function automatic logic [7:0] crc8(input logic [7:0] b);
		logic [7:0] c;
		c = CRC_INIT ^ b;
		repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
		return c;
	endfunction : crc8
	task give_verdict;
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : give_verdict
	// Cuts a hung run short.
	initial begin
		#100000;
		failures++;
		give_verdict;
	end
	// Main sequence of register accesses and events.
	initial begin
		{rst_b, wr, rd, done, fault, send, bad, mv, mu, mse} = '0;
		{addr, wdata, mb, mref, uref, fcnt, rng} = '0;
		meas = mk(4);
		failures = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst_b <= 1'b1;
		for (int a = 0; a < 5; a++) rd_chk(4'(a), 32'h0);
		rd_chk(4'hF, 32'h0);
		rd_chk(ADDR_CRC, {16'h0000, CRC_INIT, CRC_INIT});
		wr_reg(ADDR_CTRL, 32'h1);
		for (int i = 0; i < 5; i++) begin
			wr_reg(ADDR_EVT_EN, (i < 4) ? 32'h1 << i : 32'h80);
			@(posedge clk);
			meas <= mk(i);
			done <= 1'b1;
			ev(1, 1'b1);
			@(posedge clk);
			meas <= mk(4);
			done <= (i < 4);
			ev(1, 1'b0);
		end
		rd_chk(ADDR_EVT_EN, 32'h80);
		wr_reg(ADDR_CTRL, 32'h0);
		done <= 1'b1;
		ev(1, 1'b0);
		wr_reg(ADDR_CTRL, 32'h1);
		wr_reg(ADDR_EVT_EN, 32'h10);
		fcnt <= 6'd31;
		ev(1, 1'b0);
		fcnt <= 6'(FIFO_FULL_COUNT);
		ev(1, 1'b1);
		wr_reg(ADDR_EVT_EN, 32'h20);
		fcnt <= 6'd0;
		ev(1, 1'b1);
		wr_reg(ADDR_EVT_EN, 32'h40);
		wr_reg(ADDR_LEVEL, 32'h5);
		fcnt <= 6'd4;
		ev(1, 1'b0);
		fcnt <= 6'd5;
		ev(1, 1'b1);
		rd_chk(ADDR_LEVEL, 32'h5);
		wr_reg(ADDR_EVT_EN, 32'h0);
		wr_reg(ADDR_CTRL, 32'h19);
		for (int i = 0; i < 8; i++) begin
			rng <= '0;
			wr_reg(ADDR_CHK_EN, 32'h1 << i);
			rng <= ~(8'h1 << i);
			ev(1, 1'b0);
			rng <= 8'h1 << i;
			ev(1, 1'b1);
		end
		wr_reg(ADDR_CTRL, 32'h1);
		wr_reg(ADDR_CHK_EN, 32'hFF);
		rng <= '1;
		ev(1, 1'b0);
		wr_reg(ADDR_CTRL, 32'h9);
		rng <= 8'hF0;
		ev(1, 1'b0);
		rng <= 8'h0F;
		ev(1, 1'b1);
		wr_reg(ADDR_CTRL, 32'h11);
		ev(1, 1'b0);
		rng <= 8'hF0;
		ev(1, 1'b1);
		rng <= '0;
		rd_chk(ADDR_CHK_EN, 32'hFF);
		wr_reg(ADDR_CTRL, 32'h21);
		fault <= 1'b1;
		ev(1, 1'b1);
		rd_chk(ADDR_STATUS, 32'h1 << STAT_SNS);
		wr_reg(ADDR_CTRL, 32'h1);
		ev(1, 1'b0);
		fault <= 1'b0;
		wr_reg(ADDR_CTRL, 32'h3);
		send <= 1'b1;
		ev(3, 1'b0);
		{send, bad} <= 2'b11;
		ev(3, 1'b1);
		wr_reg(ADDR_CTRL, 32'h5);
		{mv, mse, mu, mb, mref} <= {3'b110, 8'h3C, crc8(8'h3C) ^ 8'h01};
		ev(2, 1'b1);
		wr_reg(ADDR_CTRL, 32'h41);
		{mv, mse, mu, uref} <= {3'b111, crc8(8'h3C)};
		ev(2, 1'b0);
		{mv, mse, mu, uref} <= {3'b111, crc8(8'h3C) ^ 8'h01};
		ev(2, 1'b1);
		rd_chk(ADDR_CTRL, 32'h41);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rd_chk(ADDR_CTRL, 32'h0);
		ev(1, 1'b0);
		give_verdict;
	end
endmodule : sensor_irq_enable_bench
